// >>> design/reference_dac_code_word_device.sv
// Device end: decodes configuration words, stores DAC codes
// Assumes host keeps pad bits zero and codes above the floor
//
// Functional notes
// - Command 1001 stores code as channel A
// - Command 1010 stores code as channel B
// - Code taken from word bits eleven to three
// - Other commands leave both DAC codes unchanged
// - Host drives the three low bits zero in DAC code words
// - Codes reset to 1FF; host avoids 064 downward
// - Host trims by trying eleven neighbouring codes
// - 0011 reads, 1000 writes main configuration
`timescale 1ns/100ps
`include "reference_dac_code_word_defines.svh"
module reference_dac_code_word_device
(
  input  wire logic               i_clock,
  input  wire logic               i_sys_rst,
  reference_dac_code_word_if.device_end            link,
  output reference_dac_code_word_pkg::dac_code_t   o_channel_a_dac_code,
  output reference_dac_code_word_pkg::dac_code_t   o_channel_b_dac_code,
  output logic [11:0]             o_main_configuration_word
);

  // Overview of the data path
  // One strobed word arrives per valid cycle from the host end.
  // The top four bits pick what the word does.
  // Two commands load a channel code, one loads the main
  // configuration bits, one asks for those bits back.
  // Every other command pattern falls through untouched.
  // All stores are plain flip-flops with a synchronous reset.
  // Every output comes straight from one of those flip-flops.

  // Decode helper: a strobed word that carries a given command
  // Used for all four command decodes, so they stay alike
  function automatic logic cmd_hits
  (
    input logic                              valid,
    input reference_dac_code_word_pkg::command_select_field_t field,
    input reference_dac_code_word_pkg::command_select_field_t pattern
  );
    cmd_hits = valid && (field == pattern);
  endfunction

  // Stored state
  reference_dac_code_word_pkg::dac_code_t a_reg;   // Channel A store
  reference_dac_code_word_pkg::dac_code_t b_reg;   // Channel B store
  logic [11:0]           cfg_reg; // Main configuration low bits
  logic                  rbv_reg; // Readback strobe
  logic [11:0]           rb_reg;  // Readback data

  // Field split of the incoming word
  // Command field sits in the top four bits
  wire reference_dac_code_word_pkg::command_select_field_t cmd = link.word[`CMD_MSB:`CMD_LSB];

  // Nine-bit code field, most significant bit first
  wire reference_dac_code_word_pkg::dac_code_t code = link.word[`CODE_MSB:`CODE_LSB];

  // Low twelve bits carry the main configuration payload
  wire [11:0] cfg_bits = link.word[`CFG_MSB:`CFG_LSB];

  // Pad bits are not checked here; the host keeps them zero
  wire [2:0] pad_bits = link.word[`PAD_MSB:`PAD_LSB];

  // Command decodes
  // Channel A load
  wire wr_a   = cmd_hits(link.word_valid, cmd, `CMD_WRITE_DAC_A);

  // Channel B load
  wire wr_b   = cmd_hits(link.word_valid, cmd, `CMD_WRITE_DAC_B);

  // Main configuration load
  wire wr_cfg = cmd_hits(link.word_valid, cmd, `CMD_WRITE_CONFIG);

  // Main configuration readback request
  wire rd_cfg = cmd_hits(link.word_valid, cmd, `CMD_READ_CONFIG);

  // Any other strobed word: decoded but has no effect
  wire ignored = link.word_valid && !(wr_a || wr_b || wr_cfg || rd_cfg);

  // Next values
  // Channel A: load on its own command, otherwise hold
  // A write to B can never reach this store
  wire reference_dac_code_word_pkg::dac_code_t a_next = wr_a ? code : a_reg;

  // Channel B: load on its own command, otherwise hold
  // A write to A can never reach this store
  wire reference_dac_code_word_pkg::dac_code_t b_next = wr_b ? code : b_reg;

  // Main configuration: load low twelve bits, otherwise hold
  wire [11:0] cfg_next = wr_cfg ? cfg_bits : cfg_reg;

  // Readback strobe follows a read request by one cycle
  wire rbv_next = rd_cfg;

  // Readback data is taken from the store only on a read
  // It then holds, so the host may sample it late
  wire [11:0] rb_next = rd_cfg ? cfg_reg : rb_reg;

  // Channel A code store
  // Reset puts the code at the top of its range
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      a_reg <= `DAC_CODE_RESET;
    end
    else
    begin
      a_reg <= a_next;
    end
  end

  // Channel B code store
  // Kept apart from channel A on purpose
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      b_reg <= `DAC_CODE_RESET;
    end
    else
    begin
      b_reg <= b_next;
    end
  end

  // Main configuration store
  // Only the low twelve bits are kept; command bits are not
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      cfg_reg <= `CONFIG_RESET;
    end
    else
    begin
      cfg_reg <= cfg_next;
    end
  end

  // Readback strobe
  // One-cycle pulse per read request; back-to-back reads
  // give a strobe on each cycle
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      rbv_reg <= 1'b0;
    end
    else
    begin
      rbv_reg <= rbv_next;
    end
  end

  // Readback data
  // A load and a read in one cycle cannot happen: one word
  // carries one command, so the old value is always returned
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      rb_reg <= `CONFIG_RESET;
    end
    else
    begin
      rb_reg <= rb_next;
    end
  end

  // Outputs
  // Each channel code drives its own reference DAC
  assign o_channel_a_dac_code      = a_reg;
  assign o_channel_b_dac_code      = b_reg;

  // Stored configuration bits for the rest of the converter
  assign o_main_configuration_word = cfg_reg;

  // Readback answer back to the host end
  assign link.readback_valid       = rbv_reg;
  assign link.readback             = rb_reg;

  // Notes for users of this block
  // Codes at or below the floor are not refused here; the
  // host end refuses them before they reach the link.
  // Pad bits and ignored words are visible on wires above
  // for any later checker but change no state.
  // Trimming around a target code is a host procedure:
  // each trial is an ordinary channel write.
endmodule

// >>> design/reference_dac_code_word_defines.svh
// Constants for the reference DAC code register block
// Assumes inclusion by both ends; the interface does not include it
`ifndef REFERENCE_DAC_CODE_WORD_DEFINES_SVH
`define REFERENCE_DAC_CODE_WORD_DEFINES_SVH
`define CMD_MSB           15
`define CMD_LSB           12
`define CODE_MSB          11
`define CODE_LSB          3
`define PAD_MSB           2
`define PAD_LSB           0
`define CFG_MSB           11
`define CFG_LSB           0
`define CMD_READ_CONFIG   4'h3
`define CMD_WRITE_CONFIG  4'h8
`define CMD_WRITE_DAC_A   4'h9
`define CMD_WRITE_DAC_B   4'hA
`define DAC_CODE_RESET    9'h1FF
`define DAC_CODE_FLOOR    9'h064
`define CONFIG_RESET      12'h000
`define WORD_RESET        16'h0000
`define REF_DAC_WORD_OFFSET 4'h2
`endif

// >>> design/reference_dac_code_word_pkg.sv
// Types shared by both ends of the configuration word link
package reference_dac_code_word_pkg;
  typedef logic [15:0] config_word_t;
  typedef logic [8:0]  dac_code_t;
  typedef logic [3:0]  command_select_field_t;
endpackage

// >>> design/reference_dac_code_word_if.sv
// Link carrying one 16-bit configuration word per valid cycle
// Assumes both ends share i_clock
`timescale 1ns/100ps
interface reference_dac_code_word_if;
  logic                  word_valid; // Word strobe, one cycle
  reference_dac_code_word_pkg::config_word_t word;    // Received configuration word
  logic                  readback_valid; // Readback strobe
  logic [11:0]           readback;   // Main configuration readback
  modport device_end (input word_valid, input word, output readback_valid, output readback);
  modport host_end   (output word_valid, output word, input readback_valid, input readback);
endinterface

// >>> design/reference_dac_code_word_host.sv
// Host end: turns user requests into configuration words
// Assumes device samples the word on its valid cycle
`timescale 1ns/100ps
`include "reference_dac_code_word_defines.svh"
module reference_dac_code_word_host
(
  input  wire logic                           i_clock,
  input  wire logic                           i_sys_rst,
  reference_dac_code_word_if.host_end                          link,
  input  wire logic                           i_req,
  input  wire reference_dac_code_word_pkg::command_select_field_t i_cmd,
  input  wire reference_dac_code_word_pkg::dac_code_t          i_code,
  input  wire logic [11:0]                    i_config,
  output logic                                o_rejected,
  output logic                                o_readback_valid,
  output logic [11:0]                         o_readback
);
  // DAC writes must stay above the floor code
  wire is_dac  = (i_cmd == `CMD_WRITE_DAC_A) || (i_cmd == `CMD_WRITE_DAC_B);
  wire too_low = is_dac && (i_code <= `DAC_CODE_FLOOR);
  // DAC words carry code and zero pad bits
  wire reference_dac_code_word_pkg::config_word_t dac_word = {i_cmd, i_code, 3'h0};
  wire reference_dac_code_word_pkg::config_word_t cfg_word = {i_cmd, i_config};
  logic                     v_reg;
  reference_dac_code_word_pkg::config_word_t w_reg;
  logic                     rej_reg;
  logic                     rbv_reg;
  logic [11:0]              rb_reg;

  // Issue words, refusing codes at or below floor
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      v_reg   <= 1'b0;
      w_reg   <= `WORD_RESET;
      rej_reg <= 1'b0;
    end
    else
    begin
      v_reg   <= i_req && !too_low;
      rej_reg <= i_req && too_low;
      if (i_req && !too_low) w_reg <= is_dac ? dac_word : cfg_word;
    end
  end

  // Capture readback answers
  always_ff @(posedge i_clock)
  begin
    if (i_sys_rst)
    begin
      rbv_reg <= 1'b0;
      rb_reg  <= `CONFIG_RESET;
    end
    else
    begin
      rbv_reg <= link.readback_valid;
      if (link.readback_valid) rb_reg <= link.readback;
    end
  end

  assign link.word_valid  = v_reg;
  assign link.word        = w_reg;
  assign o_rejected       = rej_reg;
  assign o_readback_valid = rbv_reg;
  assign o_readback       = rb_reg;
endmodule

// >>> verif/reference_dac_code_word_assertions.sv
// Link checker
// Sees link signals only
`timescale 1ns/100ps
module reference_dac_code_word_assertions (
  input wire logic i_clock,
  input wire logic i_sys_rst,
  input wire logic word_valid,
  input wire logic [15:0] word,
  input wire logic readback_valid,
  input wire logic [11:0] readback
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_sys_rst);
  sequence dac_s; word_valid && word[15:12] inside {4'h9, 4'hA}; endsequence
  sequence rd_s; word_valid && word[15:12] == 4'h3; endsequence
  pad_zero_a: assert property (dac_s |-> word[2:0] == 3'h0) else $error("pad");
  code_floor_a: assert property (dac_s |-> word[11:3] > 9'h064) else $error("floor");
  read_answer_a: assert property (rd_s |=> readback_valid) else $error("no answer");
  read_cause_a: assert property (!(word_valid && word[15:12] == 4'h3) |=> !readback_valid) else $error("stray");
  readback_hold_a: assert property (!readback_valid |-> $stable(readback)) else $error("moved");
  word_hold_a: assert property (!word_valid |-> $stable(word)) else $error("word moved");
endmodule

// >>> verif/reference_dac_code_register_tb_top.sv
// Host and device bench
// Compile after design and checker
`timescale 1ns/100ps
module reference_dac_code_register_tb_top;
  logic i_clock = 1'b0, i_sys_rst = 1'b1, i_req = 1'b0, rej, r, rv;
  logic [3:0] i_cmd = 4'h0;
  logic [8:0] i_code = 9'h000, a, b;
  logic [11:0] i_config = 12'h000, cfg, rb;
  int error_cnt = 0, n_tests = 0;
  reference_dac_code_word_if lk ();
  reference_dac_code_word_device u_reference_dac_code_word_device (.i_clock, .i_sys_rst, .link(lk.device_end), .o_channel_a_dac_code(a),
    .o_channel_b_dac_code(b), .o_main_configuration_word(cfg));
  reference_dac_code_word_host u_reference_dac_code_word_host (.i_clock, .i_sys_rst, .link(lk.host_end), .i_req, .i_cmd, .i_code, .i_config,
    .o_rejected(rej), .o_readback_valid(rv), .o_readback(rb));
  reference_dac_code_word_assertions u_reference_dac_code_word_assertions (.i_clock, .i_sys_rst, .word_valid(lk.word_valid), .word(lk.word),
    .readback_valid(lk.readback_valid), .readback(lk.readback));
  // Clock
  initial forever #4 i_clock = ~i_clock;
  task chk(input logic ok, input string m);
    n_tests++;
    error_cnt += ok !== 1'b1;
    if (ok !== 1'b1) $display("CHECK FAILED %0t %s", $time, m);
  endtask
  task send(input logic [3:0] c, input logic [8:0] d);
    {i_cmd, i_code, i_config, i_req} = {c, d, 3'h0, d, 1'b1};
    @(posedge i_clock) #1 {i_req, r} = {1'b0, rej};
    repeat (4) @(posedge i_clock) #1;
  endtask
  task t_chan;
    chk(a === 9'h1FF && b === 9'h1FF && cfg === 12'h000, "reset");
    {i_cmd, i_code, i_req} = {4'h9, 9'h1FE, 1'b1};
    @(posedge i_clock) #1;
    send(4'hA, 9'h069);
    chk(a === 9'h1FE && b === 9'h069, "A B");
  endtask
  task t_cmds;
    send(4'h8, 9'h1A3);
    send(4'h3, 9'h000);
    chk(cfg === 12'h1A3 && rb === 12'h1A3, "config");
    chk(a === 9'h1FE && b === 9'h069, "codes");
  endtask
  task t_floor;
    send(4'h9, 9'h064);
    chk(r === 1'b1 && a === 9'h1FE, "floor");
    send(4'hA, 9'h065);
    chk(r === 1'b0 && b === 9'h065, "above floor");
    send(4'hA, 9'h000);
    chk(r === 1'b1 && b === 9'h065, "floor B");
  endtask
  task t_other;
    send(4'h5, 9'h0AA);
    send(4'h0, 9'h155);
    chk(a === 9'h1FE && b === 9'h065 && cfg === 12'h1A3, "ignored");
  endtask
  task t_read;
    {i_cmd, i_req} = {4'h3, 1'b1};
    @(posedge i_clock) #1 i_req = 1'b0;
    repeat (2) @(posedge i_clock) #1;
    chk(rv === 1'b1 && rb === 12'h1A3, "readback pulse");
    @(posedge i_clock) #1;
    chk(rv === 1'b0 && rb === 12'h1A3, "readback hold");
  endtask
  task t_trim;
    for (int k = 0; k < 11; k++)
    begin
      send(4'hA, 9'h1A9 + 9'(k));
      chk(b === 9'h1A9 + 9'(k) && a === 9'h1FE, "trim");
    end
  endtask
  // Run
  initial
  begin
    #45 i_sys_rst = 1'b0;
    t_chan;
    t_cmds;
    t_floor;
    t_other;
    t_read;
    t_trim;
    test_done;
  end
  // Watchdog
  initial
  begin
    #4000 error_cnt++;
    test_done;
  end
  task test_done;
    $display("%0d checks, %0d errors", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
endmodule
